// ==== core/cpu_seq_map.svh ====
// How it works
// - prefetch in idle cycles, buffer only prefixes
// - prefetch enable sampled at instruction first fetch
// - second-byte trap: three flushes, acknowledge, pushes
// - second-byte trap pushes start address plus one
// - third-byte trap: read, two flushes, acknowledge, pushes
// - third-byte trap pushes start address plus two
// - non-maskable request latched from one edge
// - nmi: abort, acknowledge, two pushes, fixed entry
// - interrupt enable kept across non-maskable service
// - mode 0 decodes vector bits as restart
// - mode 1 enters fixed entry after pushes
// - mode 2 reads vector table then pushes
// - bus request examined at boundaries and at each halt or sleep cycle end
// - bus grant at least one cycle late
// - bus request blocks halt and sleep exit
// - halt holds until nmi or enabled interrupt
// - halt indicator at least two clocks wide
// - sleep ends on any interrupt or nmi
// - disabled sleep resumes on request rising edge
// - first-cycle marker opens transactions, never in halt
// - at most one transaction indicator at once
`ifndef CPU_SEQ_MAP_SVH
`define CPU_SEQ_MAP_SVH

`define NMI_ENTRY   16'h0066
`define MODE1_ENTRY 16'h0038
`define TRAP_ENTRY  16'h0000
`define PFX_CB      8'hcb
`define PFX_DD      8'hdd
`define PFX_ED      8'hed
`define PFX_FD      8'hfd
`define TRAP2_FLUSH 2'h3
`define TRAP3_FLUSH 2'h2
`define FLUSH_LAST  2'h1
`define IM_MODE0    2'h0
`define IM_MODE1    2'h1
`define IM_MODE2    2'h2
`define ONE16       16'h0001
`define TWO16       16'h0002
`define VEC_ODD     8'h01
`define RST_ADDR(v) {10'h000, v[5:3], 3'h0}
`define SEQ_RESET   '0

`endif

// ==== core/cpu_seq_pkg.sv ====
package cpu_seq_pkg;

   typedef enum logic [3:0] {
      S_RUN      = 4'h0,
      S_PREF     = 4'h1,
      S_XREAD    = 4'h2,
      S_FLUSH    = 4'h3,
      S_ABORT    = 4'h4,
      S_IACK     = 4'h5,
      S_CALC     = 4'h6,
      S_TBL_LO   = 4'h7,
      S_TBL_HI   = 4'h8,
      S_PUSH_HI  = 4'h9,
      S_PUSH_LO  = 4'ha,
      S_FETCH    = 4'hb,
      S_HALT     = 4'hc,
      S_SLEEP    = 4'hd,
      S_DMA_WAIT = 4'he,
      S_DMA      = 4'hf
   } seq_state_e;

   typedef enum logic [2:0] {
      C_TRAP  = 3'h0,
      C_NMI   = 3'h1,
      C_MODE0 = 3'h2,
      C_MODE1 = 3'h3,
      C_MODE2 = 3'h4
   } cause_e;

   typedef struct packed {
      logic nmi;
      logic mreq0;
      logic mreq1;
      logic mreq2;
      logic dma;
      logic pf_en;
   } pin_req_s;

   typedef struct packed {
      logic        boundary;
      logic        calc_cycle;
      logic        halt_exec;
      logic        sleep_exec;
      logic        trap2;
      logic        trap3;
      logic        trap_clr;
      logic        pfx_take;
      logic        ie;
      logic        internal_irq;
      logic [1:0]  int_mode;
      logic [7:0]  i_reg;
      logic [15:0] sp;
      logic [15:0] next_pc;
      logic [15:0] start_pc;
      logic [15:0] idx_addr;
   } core_evt_s;

   typedef struct packed {
      logic first_cycle_marker;
      logic mem_tran;
      logic mem_rd;
      logic mem_wr;
      logic iack_tran;
      logic nmiack_tran;
      logic halt_tran;
      logic sleep_tran;
      logic ivec_rd;
   } bus_s;

   typedef struct packed {
      seq_state_e  state;
      logic        ph;
      seq_state_e  ret;
      cause_e      cause;
      logic [1:0]  cnt;
      logic [15:0] push;
      logic [7:0]  vec;
      logic [7:0]  tbl_lo;
      logic [15:0] target;
      logic        ie_entry;
      logic        nmi_pend;
      logic        mreq_prev;
      logic        rise_seen;
   } seq_s;

endpackage : cpu_seq_pkg

// ==== core/pin_sync.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "cpu_seq_map.svh"

module pin_sync
   import cpu_seq_pkg::*;
(
   // clock and reset
   input  wire logic     core_clk,
   input  wire logic     reset,
   // raw pins and synchronised copy
   input  wire pin_req_s raw,
   output var  pin_req_s sync_ff
);

   pin_req_s meta_ff;
   pin_req_s nxt_meta;
   pin_req_s nxt_sync;

   always_comb begin
      nxt_meta = raw;
      nxt_sync = meta_ff;
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         meta_ff <= `SEQ_RESET;
         sync_ff <= `SEQ_RESET;
      end else begin
         meta_ff <= nxt_meta;
         sync_ff <= nxt_sync;
      end
   end

endmodule : pin_sync

`default_nettype wire

// ==== core/cpu_interrupt_halt_sequencer.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "cpu_seq_map.svh"

module cpu_interrupt_halt_sequencer
   import cpu_seq_pkg::*;
(
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        reset,
   // request pins
   input  wire logic        nmi_req,
   input  wire logic        maskable_request_zero,
   input  wire logic        maskable_request_one,
   input  wire logic        maskable_request_two,
   input  wire logic        dma_req,
   input  wire logic        en_prefetch,
   // read data
   input  wire logic [7:0]  mem_data_in,
   input  wire logic [7:0]  ivec_data_in,
   // instruction core
   input  wire core_evt_s   core_evt,
   // bus transaction
   output var  bus_s        bus_ff,
   output logic [15:0]      mem_addr_ff,
   output logic [7:0]       mem_dout_ff,
   output logic             dma_ack_ff,
   // results to the core
   output logic             jump_valid_ff,
   output logic [15:0]      jump_addr_ff,
   output logic             resume_ff,
   output logic             svc_start_ff,
   output logic             ie_saved_ff,
   output logic             pf_en_ff,
   output logic             pfx_valid_ff,
   output logic [7:0]       pfx_byte_ff,
   output logic [1:0]       trap_info_ff
);

   ////////////////////////////////////////////////////////////////////////////
   pin_req_s raw_pins;
   pin_req_s sy;

   assign raw_pins = '{nmi: nmi_req, mreq0: maskable_request_zero,
                       mreq1: maskable_request_one, mreq2: maskable_request_two,
                       dma: dma_req, pf_en: en_prefetch};

   pin_sync u_sync (
      .core_clk (core_clk),
      .reset    (reset),
      .raw      (raw_pins),
      .sync_ff  (sy)
   );

   ////////////////////////////////////////////////////////////////////////////
   seq_s        sq_ff;
   seq_s        nxt_sq;
   bus_s        nxt_bus;
   logic [15:0] nxt_addr;
   logic [7:0]  nxt_dout;
   logic        nxt_jump;
   logic [15:0] nxt_jump_addr;
   logic        nxt_resume;
   logic        nxt_svc;
   logic        nxt_ie_saved;
   logic        nxt_pf_en;
   logic        nxt_pfx_valid;
   logic [7:0]  nxt_pfx_byte;
   logic [1:0]  nxt_trap;
   logic        int_src;
   logic        mc_end;
   logic        go_nmi;
   logic        go_int;
   logic        sleep_ctx;
   logic        is_pfx;
   cause_e      int_cause;

   // mode 2 accepts any of the three requests, modes 0 and 1 only the first
   assign int_src = core_evt.internal_irq |
                    ((core_evt.int_mode == `IM_MODE2) ?
                     (sy.mreq0 | sy.mreq1 | sy.mreq2) : sy.mreq0);
   assign int_cause = (core_evt.int_mode == `IM_MODE0) ? C_MODE0 :
                      (core_evt.int_mode == `IM_MODE1) ? C_MODE1 : C_MODE2;
   assign mc_end = sq_ff.ph;
   assign sleep_ctx = (sq_ff.state == S_SLEEP) |
                      (((sq_ff.state == S_DMA_WAIT) | (sq_ff.state == S_DMA)) &
                       (sq_ff.ret == S_SLEEP));
   assign is_pfx = (mem_data_in == `PFX_CB) | (mem_data_in == `PFX_DD) |
                   (mem_data_in == `PFX_ED) | (mem_data_in == `PFX_FD);

   ////////////////////////////////////////////////////////////////////////////
   // sequencer next state
   always_comb begin
      nxt_sq = sq_ff;
      nxt_sq.ph = (sq_ff.state == S_RUN) ? 1'b0 : ~sq_ff.ph;
      nxt_sq.mreq_prev = int_src;
      nxt_sq.rise_seen = sleep_ctx & (sq_ff.rise_seen | (int_src & ~sq_ff.mreq_prev));
      nxt_jump = 1'b0;
      nxt_jump_addr = jump_addr_ff;
      nxt_resume = 1'b0;
      nxt_svc = 1'b0;
      nxt_ie_saved = ie_saved_ff;
      nxt_pf_en = pf_en_ff;
      nxt_pfx_valid = pfx_valid_ff & ~core_evt.pfx_take;
      nxt_pfx_byte = pfx_byte_ff;
      nxt_trap = trap_info_ff & ~{2{core_evt.trap_clr}};
      go_nmi = 1'b0;
      go_int = 1'b0;
      unique case (sq_ff.state)
         S_RUN: begin
            if (core_evt.trap2 | core_evt.trap3) begin
               nxt_sq.cause = C_TRAP;
               if (core_evt.trap3) begin
                  nxt_sq.push = core_evt.start_pc + `TWO16;
                  nxt_sq.cnt = `TRAP3_FLUSH;
                  nxt_sq.state = S_XREAD;
               end else begin
                  nxt_sq.push = core_evt.start_pc + `ONE16;
                  nxt_sq.cnt = `TRAP2_FLUSH;
                  nxt_sq.state = S_FLUSH;
               end
               nxt_trap = {core_evt.trap3, ~core_evt.trap3};
            end else if (core_evt.boundary) begin
               nxt_pf_en = sy.pf_en;
               if (sy.dma) begin
                  nxt_sq.ret = S_RUN;
                  nxt_sq.state = S_DMA_WAIT;
               end else if (sq_ff.nmi_pend) begin
                  go_nmi = 1'b1;
               end else if (int_src & core_evt.ie) begin
                  go_int = 1'b1;
               end else if (core_evt.halt_exec) begin
                  nxt_sq.ie_entry = core_evt.ie;
                  nxt_sq.state = S_HALT;
               end else if (core_evt.sleep_exec) begin
                  nxt_sq.ie_entry = core_evt.ie;
                  nxt_sq.state = S_SLEEP;
               end
            end else if (core_evt.calc_cycle & pf_en_ff & ~pfx_valid_ff) begin
               nxt_sq.state = S_PREF;
            end
         end
         S_PREF: begin
            if (mc_end) begin
               if (is_pfx) begin
                  nxt_pfx_valid = 1'b1;
                  nxt_pfx_byte = mem_data_in;
               end
               nxt_sq.state = S_RUN;
            end
         end
         S_XREAD: begin
            if (mc_end) nxt_sq.state = S_FLUSH;
         end
         S_FLUSH: begin
            if (mc_end) begin
               nxt_sq.cnt = sq_ff.cnt - `FLUSH_LAST;
               if (sq_ff.cnt == `FLUSH_LAST) nxt_sq.state = S_IACK;
            end
         end
         S_ABORT: begin
            if (mc_end) nxt_sq.state = S_IACK;
         end
         S_IACK: begin
            if (mc_end) begin
               nxt_sq.vec = ivec_data_in;
               unique case (sq_ff.cause)
                  C_TRAP:  nxt_sq.target = `TRAP_ENTRY;
                  C_NMI:   nxt_sq.target = `NMI_ENTRY;
                  C_MODE0: nxt_sq.target = `RST_ADDR(ivec_data_in);
                  C_MODE1: nxt_sq.target = `MODE1_ENTRY;
                  C_MODE2: nxt_sq.target = sq_ff.target;
               endcase
               nxt_sq.state = (sq_ff.cause == C_MODE2) ? S_CALC : S_PUSH_HI;
            end
         end
         S_CALC: begin
            if (mc_end) nxt_sq.state = S_TBL_LO;
         end
         S_TBL_LO: begin
            if (mc_end) begin
               nxt_sq.tbl_lo = mem_data_in;
               nxt_sq.state = S_TBL_HI;
            end
         end
         S_TBL_HI: begin
            if (mc_end) begin
               nxt_sq.target = {mem_data_in, sq_ff.tbl_lo};
               nxt_sq.state = S_PUSH_HI;
            end
         end
         S_PUSH_HI: begin
            if (mc_end) nxt_sq.state = S_PUSH_LO;
         end
         S_PUSH_LO: begin
            if (mc_end) nxt_sq.state = S_FETCH;
         end
         S_FETCH: begin
            if (mc_end) begin
               nxt_jump = 1'b1;
               nxt_jump_addr = sq_ff.target;
               nxt_sq.state = S_RUN;
            end
         end
         S_HALT: begin
            if (mc_end) begin
               if (sy.dma) begin
                  nxt_sq.ret = S_HALT;
                  nxt_sq.state = S_DMA_WAIT;
               end else if (sq_ff.nmi_pend) begin
                  go_nmi = 1'b1;
               end else if (int_src & sq_ff.ie_entry) begin
                  go_int = 1'b1;
               end
            end
         end
         S_SLEEP: begin
            if (mc_end) begin
               if (sy.dma) begin
                  nxt_sq.ret = S_SLEEP;
                  nxt_sq.state = S_DMA_WAIT;
               end else if (sq_ff.nmi_pend) begin
                  go_nmi = 1'b1;
               end else if (int_src & sq_ff.ie_entry) begin
                  go_int = 1'b1;
               end else if (sq_ff.rise_seen | (int_src & ~sq_ff.mreq_prev)) begin
                  nxt_resume = 1'b1;
                  nxt_sq.state = S_RUN;
               end
            end
         end
         S_DMA_WAIT: begin
            if (mc_end) nxt_sq.state = S_DMA;
         end
         S_DMA: begin
            if (mc_end & ~sy.dma) nxt_sq.state = sq_ff.ret;
         end
      endcase
      if (go_nmi) begin
         nxt_sq.cause = C_NMI;
         nxt_ie_saved = core_evt.ie;
      end else if (go_int) begin
         nxt_sq.cause = int_cause;
      end
      if (go_nmi | go_int) begin
         nxt_svc = 1'b1;
         nxt_sq.push = core_evt.next_pc;
         nxt_sq.state = S_ABORT;
      end
      // a request still sampled high wins over the acknowledge that clears the latch
      nxt_sq.nmi_pend = (sq_ff.nmi_pend &
                         ~((sq_ff.state == S_IACK) & (sq_ff.cause == C_NMI))) |
                        sy.nmi;
   end

   ////////////////////////////////////////////////////////////////////////////
   // bus transaction for the coming clock
   always_comb begin
      nxt_bus = '0;
      nxt_addr = mem_addr_ff;
      nxt_dout = mem_dout_ff;
      unique case (nxt_sq.state)
         S_RUN, S_FLUSH, S_CALC, S_DMA_WAIT, S_DMA: begin
            nxt_bus.halt_tran = (nxt_sq.state != S_RUN) & (nxt_sq.ret == S_HALT) &
                                ((nxt_sq.state == S_DMA_WAIT) | (nxt_sq.state == S_DMA));
            nxt_bus.sleep_tran = (nxt_sq.state != S_RUN) & (nxt_sq.ret == S_SLEEP) &
                                 ((nxt_sq.state == S_DMA_WAIT) | (nxt_sq.state == S_DMA));
         end
         S_PREF: begin
            nxt_bus.mem_tran = 1'b1;
            nxt_bus.mem_rd = nxt_sq.ph;
            nxt_addr = core_evt.next_pc;
         end
         S_XREAD: begin
            nxt_bus.mem_tran = 1'b1;
            nxt_bus.mem_rd = nxt_sq.ph;
            nxt_addr = core_evt.idx_addr;
         end
         S_ABORT: begin
            nxt_bus.mem_tran = 1'b1;
            nxt_addr = nxt_sq.push;
         end
         S_IACK: begin
            nxt_bus.nmiack_tran = (nxt_sq.cause == C_NMI);
            nxt_bus.iack_tran = (nxt_sq.cause != C_NMI);
            nxt_bus.ivec_rd = nxt_sq.ph;
         end
         S_TBL_LO: begin
            nxt_bus.mem_tran = 1'b1;
            nxt_bus.mem_rd = nxt_sq.ph;
            nxt_addr = {core_evt.i_reg, sq_ff.vec};
         end
         S_TBL_HI: begin
            nxt_bus.mem_tran = 1'b1;
            nxt_bus.mem_rd = nxt_sq.ph;
            nxt_addr = {core_evt.i_reg, sq_ff.vec | `VEC_ODD};
         end
         S_PUSH_HI: begin
            nxt_bus.mem_tran = 1'b1;
            nxt_bus.mem_wr = nxt_sq.ph;
            nxt_addr = core_evt.sp - `ONE16;
            nxt_dout = sq_ff.push[15:8];
         end
         S_PUSH_LO: begin
            nxt_bus.mem_tran = 1'b1;
            nxt_bus.mem_wr = nxt_sq.ph;
            nxt_addr = core_evt.sp - `TWO16;
            nxt_dout = sq_ff.push[7:0];
         end
         S_FETCH: begin
            nxt_bus.mem_tran = 1'b1;
            nxt_bus.mem_rd = nxt_sq.ph;
            nxt_addr = sq_ff.target;
         end
         S_HALT: nxt_bus.halt_tran = 1'b1;
         S_SLEEP: nxt_bus.sleep_tran = 1'b1;
      endcase
      nxt_bus.first_cycle_marker = ~nxt_sq.ph &
         (nxt_bus.mem_tran | nxt_bus.iack_tran | nxt_bus.nmiack_tran);
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge core_clk) begin
      if (reset) begin
         sq_ff         <= `SEQ_RESET;
         bus_ff        <= '0;
         mem_addr_ff   <= '0;
         mem_dout_ff   <= '0;
         dma_ack_ff    <= 1'b0;
         jump_valid_ff <= 1'b0;
         jump_addr_ff  <= '0;
         resume_ff     <= 1'b0;
         svc_start_ff  <= 1'b0;
         ie_saved_ff   <= 1'b0;
         pf_en_ff      <= 1'b0;
         pfx_valid_ff  <= 1'b0;
         pfx_byte_ff   <= '0;
         trap_info_ff  <= '0;
      end else begin
         sq_ff         <= nxt_sq;
         bus_ff        <= nxt_bus;
         mem_addr_ff   <= nxt_addr;
         mem_dout_ff   <= nxt_dout;
         dma_ack_ff    <= (nxt_sq.state == S_DMA);
         jump_valid_ff <= nxt_jump;
         jump_addr_ff  <= nxt_jump_addr;
         resume_ff     <= nxt_resume;
         svc_start_ff  <= nxt_svc;
         ie_saved_ff   <= nxt_ie_saved;
         pf_en_ff      <= nxt_pf_en;
         pfx_valid_ff  <= nxt_pfx_valid;
         pfx_byte_ff   <= nxt_pfx_byte;
         trap_info_ff  <= nxt_trap;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);

   a_one_indicator: assert property (
      $onehot0({bus_ff.mem_tran, bus_ff.iack_tran, bus_ff.nmiack_tran,
                bus_ff.halt_tran, bus_ff.sleep_tran}))
      else $error("two transaction indicators at once");
   a_marker_quiet: assert property (
      (bus_ff.halt_tran | bus_ff.sleep_tran) |-> !bus_ff.first_cycle_marker)
      else $error("first-cycle marker during halt or sleep");
   a_halt_width: assert property (
      $rose(bus_ff.halt_tran) |=> bus_ff.halt_tran)
      else $error("halt indicator shorter than two clocks");
   a_nmi_latch: assert property (
      sy.nmi |=> sq_ff.nmi_pend)
      else $error("nmi request not held");
   a_grant_gap: assert property (
      $rose(dma_ack_ff) |-> $past(sq_ff.state) == S_DMA_WAIT &&
                            $past(sq_ff.state, 2) == S_DMA_WAIT)
      else $error("bus grant too early");
   a_trap2_seq: assert property (
      (sq_ff.state == S_RUN && core_evt.trap2 && !core_evt.trap3)
      |=> (sq_ff.state == S_FLUSH) [*6] ##1 sq_ff.state == S_IACK)
      else $error("second-byte trap sequence wrong");
   a_trap_push: assert property (
      (sq_ff.state == S_RUN && core_evt.trap2 && !core_evt.trap3)
      |=> sq_ff.push == $past(core_evt.start_pc) + `ONE16)
      else $error("second-byte trap stacked value wrong");
   a_trap3_push: assert property (
      (sq_ff.state == S_RUN && core_evt.trap3)
      |=> sq_ff.push == $past(core_evt.start_pc) + `TWO16)
      else $error("third-byte trap stacked value wrong");
   a_nmi_entry: assert property (
      (jump_valid_ff && sq_ff.cause == C_NMI) |-> jump_addr_ff == `NMI_ENTRY)
      else $error("nmi entry address wrong");
   a_mode0_addr: assert property (
      (jump_valid_ff && sq_ff.cause == C_MODE0) |-> jump_addr_ff == `RST_ADDR(sq_ff.vec))
      else $error("restart address wrong");
   a_dma_holds: assert property (
      (sq_ff.state == S_HALT && sq_ff.ph && sy.dma) |=> sq_ff.state == S_DMA_WAIT)
      else $error("halt left while bus requested");
   a_pf_buffer: assert property (
      (sq_ff.state == S_PREF && sq_ff.ph && is_pfx) |=> pfx_valid_ff)
      else $error("prefix byte not buffered");
   a_sleep_resume: assert property (
      resume_ff |-> $past(sq_ff.state) == S_SLEEP && !$past(sq_ff.ie_entry))
      else $error("resume without disabled sleep");

   c_nmi_entry: cover property (jump_valid_ff && sq_ff.cause == C_NMI);
   c_mode2_entry: cover property (jump_valid_ff && sq_ff.cause == C_MODE2);
   c_sleep_resume: cover property (resume_ff);
   c_dma_in_halt: cover property (dma_ack_ff && bus_ff.halt_tran);

endmodule : cpu_interrupt_halt_sequencer

`default_nettype wire

// ==== verification/far_side_model.sv ====
`timescale 1ns/1ns
`default_nettype none

module far_side_model
   import cpu_seq_pkg::*;
(
   // bus from the sequencer
   input  wire bus_s        bus,
   input  wire logic [15:0] addr,
   input  wire logic [7:0]  vec,
   // read data back
   output logic [7:0]       mem_data_in,
   output logic [7:0]       ivec_data_in
);
   logic [7:0] rd;
   assign rd = addr[7:0] ^ addr[15:8] ^ 8'h3c;
   // outside a strobe the buses show the inverse
   assign mem_data_in  = bus.mem_rd ? rd : ~rd;
   assign ivec_data_in = bus.ivec_rd ? {vec[7:1], 1'b0} : ~vec;
endmodule : far_side_model

`default_nettype wire

// ==== verification/cpu_interrupt_halt_sequencer_tb.sv ====
`timescale 1ns/1ns
`default_nettype none

module cpu_interrupt_halt_sequencer_tb;
   import cpu_seq_pkg::*;
   logic        core_clk, reset, nmi_req, maskable_request_zero, dma_req;
   logic [7:0]  vec, mem_data_in, ivec_data_in, mem_dout_ff, pfx_byte;
   logic [1:0]  mreq_hi, trap_info;
   logic        pf_pin, svc_start, pf_en, pfx_valid;
   logic [15:0] mem_addr_ff, jump_addr_ff;
   logic        dma_ack_ff, jump_valid_ff, resume_ff, ie_saved_ff;
   bus_s        bus_ff;
   core_evt_s   ev;
   logic [15:0] jq[$];
   logic [7:0]  pq[$];
   int          err_total, comparisons, cyc, seed, resumes, svcs;

   cpu_interrupt_halt_sequencer cpu_interrupt_halt_sequencer_i (
      .core_clk(core_clk), .reset(reset), .nmi_req(nmi_req),
      .maskable_request_zero(maskable_request_zero), .maskable_request_one(mreq_hi[0]),
      .maskable_request_two(mreq_hi[1]), .dma_req(dma_req), .en_prefetch(pf_pin),
      .mem_data_in(mem_data_in), .ivec_data_in(ivec_data_in), .core_evt(ev),
      .bus_ff(bus_ff), .mem_addr_ff(mem_addr_ff), .mem_dout_ff(mem_dout_ff),
      .dma_ack_ff(dma_ack_ff), .jump_valid_ff(jump_valid_ff), .jump_addr_ff(jump_addr_ff),
      .resume_ff(resume_ff), .svc_start_ff(svc_start), .ie_saved_ff(ie_saved_ff),
      .pf_en_ff(pf_en), .pfx_valid_ff(pfx_valid), .pfx_byte_ff(pfx_byte),
      .trap_info_ff(trap_info));

   far_side_model far_side_model_i (
      .bus(bus_ff), .addr(mem_addr_ff), .vec(vec),
      .mem_data_in(mem_data_in), .ivec_data_in(ivec_data_in));

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] rdv(input logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h3c;
   endfunction : rdv

   task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp_word

   task automatic cmp_flag(input logic got, input logic exp);
      cmp_word({15'h0000, got}, {15'h0000, exp});
   endtask : cmp_flag

   task automatic stop_test;
      $display("errors %0d comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : stop_test

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : tick

   // pc pushed high byte first, then the entry fetch target
   task automatic exp_svc(input logic [15:0] pc, input logic [15:0] tgt);
      pq.push_back(pc[15:8]);
      pq.push_back(pc[7:0]);
      jq.push_back(tgt);
   endtask : exp_svc

   task automatic drain;
      for (int i = 0; i < 80 && jq.size() > 0; i++) tick(1);
      tick(2);
   endtask : drain

   task automatic bnd;
      ev.boundary = 1'b1;
      tick(1);
      ev.boundary = 1'b0;
   endtask : bnd

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   always @(posedge core_clk) begin
      cyc++;
      #2;
      if (jump_valid_ff === 1'b1)
         cmp_word(jump_addr_ff, jq.size() ? jq.pop_front() : 16'hxxxx);
      if (bus_ff.mem_wr === 1'b1)
         cmp_word({8'h00, mem_dout_ff}, pq.size() ? {8'h00, pq.pop_front()} : 16'hxxxx);
      if (resume_ff === 1'b1) resumes++;
      if (svc_start === 1'b1) svcs++;
      if (cyc == 20000) begin
         err_total++;
         stop_test();
      end
   end

   initial begin
      {reset, nmi_req, maskable_request_zero, dma_req, pf_pin, mreq_hi} = 7'h40;
      ev = '0;
      vec = 8'h00;
      seed = 83;
      ev.sp = 16'h8000;
      tick(16);
      reset = 1'b0;
      tick(2);
      // a one-clock nmi pulse is latched
      ev.ie = 1'b1;
      ev.next_pc = 16'($random(seed));
      nmi_req = 1'b1;
      tick(1);
      nmi_req = 1'b0;
      tick(4);
      exp_svc(ev.next_pc, 16'h0066);
      bnd();
      drain();
      cmp_flag(ie_saved_ff, 1'b1);
      // mode 0 over all eight restart slots, then modes 1 and 2
      for (int i = 0; i < 10; i++) begin
         ev.int_mode = (i < 8) ? 2'h0 : 2'(i - 7);
         vec = {2'($random(seed)), 3'(i), 3'($random(seed))} & 8'hfe;
         ev.i_reg = 8'($random(seed));
         ev.next_pc = 16'($random(seed));
         exp_svc(ev.next_pc, ev.int_mode == 2'h0 ? {8'h00, 2'h0, vec[5:3], 3'h0}
            : ev.int_mode == 2'h1 ? 16'h0038
            : {rdv({ev.i_reg, vec | 8'h01}), rdv({ev.i_reg, vec})});
         // mode 2 is raised on the other two request pins
         {mreq_hi, maskable_request_zero} = (i == 9) ? 3'h6 : 3'h1;
         tick(3);
         bnd();
         for (int j = 0; j < 20 && bus_ff.iack_tran !== 1'b1; j++) tick(1);
         {mreq_hi, maskable_request_zero} = 3'h0;
         drain();
      end
      for (int t = 0; t < 2; t++) begin
         ev.start_pc = 16'($random(seed));
         exp_svc(ev.start_pc + 16'(t + 1), 16'h0000);
         ev.trap2 = (t == 0);
         ev.trap3 = (t == 1);
         tick(1);
         {ev.trap2, ev.trap3} = 2'h0;
         drain();
         cmp_word({14'h0000, trap_info}, {14'h0000, 2'(t + 1)});
      end
      ev.trap_clr = 1'b1;
      tick(1);
      ev.trap_clr = 1'b0;
      cmp_word({14'h0000, trap_info}, 16'h0000);
      // halt with interrupts off, bus request holds it across an nmi
      ev.ie = 1'b0;
      ev.halt_exec = 1'b1;
      bnd();
      ev.halt_exec = 1'b0;
      dma_req = 1'b1;
      tick(4);
      cmp_flag(dma_ack_ff, 1'b0);
      nmi_req = 1'b1;
      tick(1);
      nmi_req = 1'b0;
      tick(10);
      cmp_flag(dma_ack_ff, 1'b1);
      cmp_flag(bus_ff.halt_tran, 1'b1);
      exp_svc(ev.next_pc, 16'h0066);
      dma_req = 1'b0;
      drain();
      cmp_flag(ie_saved_ff, 1'b0);
      // sleep with interrupts off resumes on a request edge
      ev.ie = 1'b0;
      ev.sleep_exec = 1'b1;
      bnd();
      ev.sleep_exec = 1'b0;
      tick(6);
      cmp_flag(bus_ff.sleep_tran, 1'b1);
      maskable_request_zero = 1'b1;
      tick(10);
      maskable_request_zero = 1'b0;
      cmp_flag(resumes == 1, 1'b1);
      cmp_flag(bus_ff.sleep_tran, 1'b0);
      // idle-cycle prefetch: memory at 00f7 holds a prefix, at 0000 a plain byte
      pf_pin = 1'b1;
      tick(3);
      bnd();
      cmp_flag(pf_en, 1'b1);
      for (int k = 0; k < 2; k++) begin
         ev.next_pc = k ? 16'h0000 : 16'h00f7;
         ev.calc_cycle = 1'b1;
         tick(1);
         ev.calc_cycle = 1'b0;
         tick(3);
         cmp_word({7'h00, pfx_valid, pfx_byte}, k ? 16'h00cb : 16'h01cb);
         ev.pfx_take = 1'b1;
         tick(1);
         ev.pfx_take = 1'b0;
      end
      pf_pin = 1'b0;
      tick(3);
      bnd();
      cmp_flag(pf_en, 1'b0);
      cmp_word(16'(svcs), 16'h000c);
      stop_test();
   end
endmodule : cpu_interrupt_halt_sequencer_tb

`default_nettype wire
